// >>> rtl/ddr_rx_pkg.sv
// Package for the DDR input deserializer path: sizes, encodings, helpers.
// Assumes one pad pin per instance and a strobe-clocked source outside.
package ddr_rx_pkg;
	// Delay line
	localparam int TAP_COUNT = 256;
	localparam int TAP_W = 8;
	localparam logic [TAP_W-1:0] TAP_MAX = 8'hFF;
	localparam logic [TAP_W-1:0] TAP_RST = 8'h00;
	// Dual-edge input FIFO
	localparam int IN_FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
	// Gearbox sizes
	localparam int WORD_W = 10;
	localparam int SHIFT_W = 16;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
	localparam logic [CNT_W-1:0] BITS_X2 = 4'h4;
	localparam logic [CNT_W-1:0] BITS_X3P5 = 4'h7;
	localparam logic [CNT_W-1:0] BITS_X4 = 4'h8;
	localparam logic [CNT_W-1:0] BITS_X5 = 4'hA;
	// Output buffer depth
	localparam int BUF_DEPTH = 8;
	// Deserialization ratio select
	typedef enum logic [1:0] {RATIO_X2, RATIO_X3P5, RATIO_X4, RATIO_X5} ratio_e;
	// Delay source select
	typedef enum logic [1:0] {DELAY_STATIC, DELAY_DYNAMIC, DELAY_TRAINING} delay_mode_e;

	// Bits per word for a ratio; DDR gives two bits per fast cycle
	function automatic logic [CNT_W-1:0] wordBits(input logic [1:0] r);
		case (r)
			RATIO_X2: return BITS_X2;
			RATIO_X3P5: return BITS_X3P5;
			RATIO_X4: return BITS_X4;
			default: return BITS_X5;
		endcase
	endfunction : wordBits

	// Binary to gray for pointer crossings
	function automatic logic [PTR_W-1:0] toGray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction : toGray

	// Word of n bits taken from the shift stage at bit offset off
	function automatic logic [WORD_W-1:0] pickWord(input logic [SHIFT_W-1:0] s,
			input logic [CNT_W-1:0] off, input logic [CNT_W-1:0] n);
		logic [SHIFT_W-1:0] t;
		logic [WORD_W-1:0] w;
		t = s >> off;
		for (int i = 0; i < WORD_W; i++) begin
			w[i] = (i < int'(n)) ? t[i] : 1'b0;
		end
		return w;
	endfunction : pickWord
endpackage : ddr_rx_pkg

// >>> rtl/ddr_input_deserializer_path.sv
// Receive path of one DDR pad: delay line, dual-edge FIFO, gearbox, buffer.
// Assumes the strobe clock runs whenever data is sent; core_clk runs free.
`timescale 1ns/10ps

// Word buffer with registered read side
module word_buffer_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WIDTH-1:0] wrData,
	output logic rdValid,
	input wire logic rdReady,
	output logic [WIDTH-1:0] rdData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wrPtr_q; // Next slot to fill
	logic [AW-1:0] rdPtr_q; // Next slot to drain
	logic [AW:0] count_q; // Words held in memory
	logic doWrite;
	logic doRead;

	// Full stalls the writer; the output register drains independently
	assign wrReady = (count_q != (AW+1)'(DEPTH));
	assign doWrite = wrValid && wrReady;
	assign doRead = (count_q != '0) && (!rdValid || rdReady);

	// Memory and pointers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doWrite) begin
				mem[wrPtr_q] <= wrData;
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
			end
			if (doRead) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
			end
			count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end

	// Output register, so the consumer sees flop outputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdValid <= 1'b0;
			rdData <= '0;
		end else if (doRead) begin
			rdValid <= 1'b1;
			rdData <= mem[rdPtr_q];
		end else if (rdReady) begin
			rdValid <= 1'b0;
		end
	end
endmodule : word_buffer_fifo

// Notes on behaviour
// R1: Input delay selectable among 256 taps
// R2: Static mode holds fixed configured tap
// R3: Dynamic mode takes tap from DLL code
// R4: Training logic steers tap while running
// R5: Two 8-deep arrays: rise, fall bits
// R6: Rise bit moved half cycle; falling-edge writes
// R7: 3-bit write and read pointers
// R8: FIFO carries data into core domain
// R9: Shift stage takes a bit pair on each consume
// R10: Update stage loads on ratio strobe
// R11: Transfer stage on core clock to fabric
// R12: Slip moves boundary one bit, not 3.5
// R13: Pointers wrap eight; never read empty
module ddr_input_deserializer_path import ddr_rx_pkg::*; #(
	parameter logic [TAP_W-1:0] STATIC_TAP = 8'h20
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic bankFastIoClk,
	input wire logic padData,
	input wire logic [1:0] delayMode,
	input wire logic [TAP_W-1:0] dllCode,
	input wire logic trainLoad,
	input wire logic [TAP_W-1:0] trainValue,
	input wire logic trainInc,
	input wire logic trainDec,
	input wire logic [1:0] ratioSel,
	input wire logic slipEnable,
	input wire logic wordAlignSlip,
	input wire logic wordReady,
	output logic [WORD_W-1:0] wordData,
	output logic wordValid,
	output logic [TAP_W-1:0] tapNow,
	output logic tapBusy
);
	// Reset copies for each domain
	logic coreRst1_q, coreRstn_q;
	logic linkRst1_q, linkRstn_q;
	// Tap selection and crossing
	logic [TAP_W-1:0] tapTarget_q; // Wanted tap, core side
	logic [TAP_W-1:0] tapSent_q; // Tap held stable during crossing
	logic tapReq_q; // Request toggle, core
	logic ackSync1_q, ackSync2_q; // Ack back into core
	logic reqSync1_q, reqSync2_q, reqSync3_q; // Request into link
	logic [TAP_W-1:0] tapLink_q; // Tap in use at the pad
	// Delay line histories
	logic [TAP_COUNT-1:0] riseHist_q;
	logic [TAP_COUNT-2:0] fallHist_q;
	logic riseSel, fallSel;
	// Input FIFO
	logic riseArr_q [IN_FIFO_DEPTH];
	logic fallArr_q [IN_FIFO_DEPTH];
	logic [PTR_W-1:0] wPtr_q, wGray_q, rSync1_q, rSync2_q;
	logic [PTR_W-1:0] rPtr_q, rGray_q, wSync1_q, wSync2_q;
	logic inFull, inEmpty, readEn;
	// Gearbox stages
	logic pairValid_q, pairRise_q, pairFall_q;
	logic [SHIFT_W-1:0] shift_q, shiftNext;
	logic [CNT_W-1:0] bitCount_q, bitsNeed, bitSum;
	logic slipPending_q, slipNow, consume, updLoad, stall;
	logic [WORD_W-1:0] updWord_q, xferWord_q;
	logic updValid_q, xferValid_q, bufReady;

	// Reset release into core domain
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			coreRst1_q <= 1'b0;
			coreRstn_q <= 1'b0;
		end else begin
			coreRst1_q <= 1'b1;
			coreRstn_q <= coreRst1_q;
		end
	end

	// Reset release into link domain
	always_ff @(posedge bankFastIoClk or negedge resetn) begin
		if (!resetn) begin
			linkRst1_q <= 1'b0;
			linkRstn_q <= 1'b0;
		end else begin
			linkRst1_q <= 1'b1;
			linkRstn_q <= linkRst1_q;
		end
	end

	// Tap source per delay mode; training saturates at the ends
	always_ff @(posedge core_clk or negedge coreRstn_q) begin
		if (!coreRstn_q) begin
			tapTarget_q <= TAP_RST;
		end else begin
			case (delayMode)
				// R2: fixed tap
				DELAY_STATIC: tapTarget_q <= STATIC_TAP;
				// R3: DLL code
				DELAY_DYNAMIC: tapTarget_q <= dllCode;
				// R4: training controls
				DELAY_TRAINING: begin
					if (trainLoad) begin
						tapTarget_q <= trainValue;
					end else if (trainInc && tapTarget_q != TAP_MAX) begin
						tapTarget_q <= tapTarget_q + 8'h01;
					end else if (trainDec && tapTarget_q != TAP_RST) begin
						tapTarget_q <= tapTarget_q - 8'h01;
					end
				end
				default: tapTarget_q <= tapTarget_q;
			endcase
		end
	end

	// R1: tap handshake
	// Toggle request holds tapSent stable until the link echoes it back
	always_ff @(posedge core_clk or negedge coreRstn_q) begin
		if (!coreRstn_q) begin
			tapSent_q <= TAP_RST;
			tapReq_q <= 1'b0;
			ackSync1_q <= 1'b0;
			ackSync2_q <= 1'b0;
			tapBusy <= 1'b0;
			tapNow <= TAP_RST;
		end else begin
			ackSync1_q <= reqSync3_q;
			ackSync2_q <= ackSync1_q;
			if (tapReq_q == ackSync2_q && !tapBusy && tapSent_q != tapTarget_q) begin
				tapSent_q <= tapTarget_q;
				tapReq_q <= ~tapReq_q;
				tapBusy <= 1'b1;
			end else if (tapReq_q == ackSync2_q) begin
				tapBusy <= 1'b0;
				tapNow <= tapSent_q;
			end
		end
	end

	// R4: tap taken at the pad
	// Updates land while data keeps flowing; a step may glitch one bit
	always_ff @(posedge bankFastIoClk or negedge linkRstn_q) begin
		if (!linkRstn_q) begin
			reqSync1_q <= 1'b0;
			reqSync2_q <= 1'b0;
			reqSync3_q <= 1'b0;
			tapLink_q <= TAP_RST;
		end else begin
			reqSync1_q <= tapReq_q;
			reqSync2_q <= reqSync1_q;
			reqSync3_q <= reqSync2_q;
			if (reqSync2_q != reqSync3_q) begin
				tapLink_q <= tapSent_q;
			end
		end
	end

	// R1: rising-edge history; the tap picks how many cycles back
	always_ff @(posedge bankFastIoClk or negedge linkRstn_q) begin
		if (!linkRstn_q) begin
			riseHist_q <= '0;
		end else begin
			riseHist_q <= {riseHist_q[TAP_COUNT-2:0], padData};
		end
	end

	// Falling-edge history
	always_ff @(negedge bankFastIoClk or negedge linkRstn_q) begin
		if (!linkRstn_q) begin
			fallHist_q <= '0;
		end else begin
			fallHist_q <= {fallHist_q[TAP_COUNT-3:0], padData};
		end
	end

	// R1: delayed bits, tap zero passes the fall bit straight through; the rise bit comes from riseHist_q[0]
	assign riseSel = riseHist_q[tapLink_q];
	assign fallSel = (tapLink_q == TAP_RST) ? padData : fallHist_q[tapLink_q - 8'h01];

	// R7: full keeps one slot spare so 3-bit pointers suffice
	assign inFull = (toGray(wPtr_q + PTR_ONE) == rSync2_q);

	// R6: falling-edge write of both arrays
	// The rise bit has sat half a cycle in the history by now
	always_ff @(negedge bankFastIoClk or negedge linkRstn_q) begin
		if (!linkRstn_q) begin
			wPtr_q <= '0;
			wGray_q <= '0;
			rSync1_q <= '0;
			rSync2_q <= '0;
		end else begin
			rSync1_q <= rGray_q;
			rSync2_q <= rSync1_q;
			// R5: rise and fall arrays
			if (!inFull) begin
				riseArr_q[wPtr_q] <= riseSel;
				fallArr_q[wPtr_q] <= fallSel;
				wPtr_q <= wPtr_q + PTR_ONE;
				wGray_q <= toGray(wPtr_q + PTR_ONE);
			end
		end
	end

	// R13: empty when pointers meet; nothing read before a write lands
	assign inEmpty = (rGray_q == wSync2_q);
	assign consume = pairValid_q && !stall;
	assign readEn = !inEmpty && (!pairValid_q || consume);

	// R8: read side in core domain
	always_ff @(posedge core_clk or negedge coreRstn_q) begin
		if (!coreRstn_q) begin
			wSync1_q <= '0;
			wSync2_q <= '0;
			rPtr_q <= '0;
			rGray_q <= '0;
			pairValid_q <= 1'b0;
			pairRise_q <= 1'b0;
			pairFall_q <= 1'b0;
		end else begin
			wSync1_q <= wGray_q;
			wSync2_q <= wSync1_q;
			if (readEn) begin
				pairRise_q <= riseArr_q[rPtr_q];
				pairFall_q <= fallArr_q[rPtr_q];
				rPtr_q <= rPtr_q + PTR_ONE;
				rGray_q <= toGray(rPtr_q + PTR_ONE);
				pairValid_q <= 1'b1;
			end else if (consume) begin
				pairValid_q <= 1'b0;
			end
		end
	end

	// R12: slip honoured only when enabled and ratio is whole
	assign slipNow = wordAlignSlip && slipEnable && (ratioSel != RATIO_X3P5);
	assign bitsNeed = wordBits(ratioSel);
	// R9: two bits enter per pair, rise bit older
	assign shiftNext = {shift_q[SHIFT_W-3:0], pairRise_q, pairFall_q};
	assign bitSum = bitCount_q + CNT_TWO + CNT_W'(slipPending_q || slipNow);
	// R10: update strobe once a word's worth has gathered
	assign updLoad = consume && (bitSum >= bitsNeed);
	// Hold the gearbox while the word ahead cannot move on
	assign stall = updValid_q && xferValid_q && !bufReady;

	// Shift stage and bit count
	always_ff @(posedge core_clk or negedge coreRstn_q) begin
		if (!coreRstn_q) begin
			shift_q <= '0;
			bitCount_q <= '0;
			slipPending_q <= 1'b0;
		end else begin
			if (consume) begin
				shift_q <= shiftNext;
				bitCount_q <= updLoad ? bitSum - bitsNeed : bitSum;
				// R12: pending slip taken; a new one in the same cycle is taken too, merged with any pending one
				slipPending_q <= 1'b0;
			end else if (slipNow) begin
				slipPending_q <= 1'b1;
			end
		end
	end

	// R10: update stage
	always_ff @(posedge core_clk or negedge coreRstn_q) begin
		if (!coreRstn_q) begin
			updWord_q <= '0;
			updValid_q <= 1'b0;
		end else if (updLoad) begin
			updWord_q <= pickWord(shiftNext, bitSum - bitsNeed, bitsNeed);
			updValid_q <= 1'b1;
		end else if (updValid_q && (!xferValid_q || bufReady)) begin
			updValid_q <= 1'b0;
		end
	end

	// R11: transfer stage facing fabric
	always_ff @(posedge core_clk or negedge coreRstn_q) begin
		if (!coreRstn_q) begin
			xferWord_q <= '0;
			xferValid_q <= 1'b0;
		end else if (updValid_q && (!xferValid_q || bufReady)) begin
			xferWord_q <= updWord_q;
			xferValid_q <= 1'b1;
		end else if (bufReady) begin
			xferValid_q <= 1'b0;
		end
	end

	// Buffer absorbs fabric back-pressure before the gearbox stalls
	word_buffer_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(BUF_DEPTH)
	) uBuffer (
		.clk(core_clk),
		.rstn(coreRstn_q),
		.wrValid(xferValid_q),
		.wrReady(bufReady),
		.wrData(xferWord_q),
		.rdValid(wordValid),
		.rdReady(wordReady),
		.rdData(wordData)
	);

	// Core-domain checks
	default clocking coreCb @(posedge core_clk);
	endclocking
	default disable iff (!coreRstn_q);

	// Target still holds its reset value on the first edge after release
	static_tap_a: assert property ($past(coreRstn_q) && $past(delayMode) == DELAY_STATIC // R2
			|-> tapTarget_q == STATIC_TAP)
		else $error("static mode tap differs from configured value");
	dll_tap_a: assert property ($past(coreRstn_q) && $past(delayMode) == DELAY_DYNAMIC // R3
			|-> tapTarget_q == $past(dllCode))
		else $error("dynamic mode tap does not follow DLL code");
	train_step_a: assert property (delayMode == DELAY_TRAINING && !trainLoad && trainInc
			&& tapTarget_q != TAP_MAX |=> tapTarget_q == $past(tapTarget_q) + 8'h01) // R4
		else $error("training increment not applied");
	tap_cross_a: assert property ($rose(tapBusy) |-> tapBusy [*4] ##[1:12] (!tapBusy && tapNow == $past(tapSent_q))) // R1
		else $error("tap change not completed in time");
	// Empty and no pair held: nothing may load and the read pointer stays put
	no_empty_read_a: assert property (inEmpty && !pairValid_q |=> !pairValid_q && $stable(rPtr_q)) // R13
		else $error("read from empty input FIFO");
	slip_gate_a: assert property (wordAlignSlip && ratioSel == RATIO_X3P5 && !consume && !slipPending_q
			|=> !slipPending_q) // R12
		else $error("slip accepted in 3.5 ratio");
	update_load_a: assert property (updLoad |=> updValid_q && bitCount_q < bitsNeed) // R10
		else $error("update stage not loaded on strobe");
	xfer_move_a: assert property (updValid_q && !xferValid_q |=> xferValid_q && xferWord_q == $past(updWord_q)) // R11
		else $error("transfer stage did not take update word");
	shift_take_a: assert property (consume |=> shift_q[1:0] == {$past(pairRise_q), $past(pairFall_q)}) // R9
		else $error("shift stage missed a pair");

	cover_slip_c: cover property (slipNow ##1 updLoad);
	cover_ratio35_c: cover property (ratioSel == RATIO_X3P5 && updLoad);
	cover_stall_c: cover property (stall [*3]);
	cover_train_c: cover property (delayMode == DELAY_TRAINING && $rose(tapBusy));

	// Link-side write check
	array_write_a: assert property (@(negedge bankFastIoClk) disable iff (!linkRstn_q)
			!inFull |=> riseArr_q[$past(wPtr_q)] == $past(riseSel)
			&& fallArr_q[$past(wPtr_q)] == $past(fallSel)) // R6
		else $error("dual-edge FIFO write lost a bit");
	full_hold_a: assert property (@(negedge bankFastIoClk) disable iff (!linkRstn_q)
			inFull |=> wPtr_q == $past(wPtr_q)) // R7
		else $error("write pointer moved while full");
endmodule : ddr_input_deserializer_path

// >>> verification/ddr_tx_model.sv
// Far-side transmitter model: strobe clock and one DDR data pad.
// Assumes the bench loads txBits and calls sendPairs; clock idles low.
`timescale 1ns/10ps
module ddr_tx_model (
	output logic linkClk,
	output logic padData
);
	bit txBits[$]; // Bits to send, oldest first
	// Idle pad and stopped clock at time zero
	initial begin
		linkClk = 1'b0;
		padData = 1'b0;
	end
	// One 6 ns link cycle per pair, rise bit first, edges mid-bit
	task automatic sendPairs(input int pairs);
		#0.7;
		for (int i = 0; i < pairs; i++) begin
			padData = txBits.pop_front();
			#1.5 linkClk = 1'b1;
			#1.5 padData = txBits.pop_front();
			#1.5 linkClk = 1'b0;
			#1.5;
		end
		// Released pad shows the inverse, so a stale bit never passes
		padData = ~padData;
	endtask : sendPairs
endmodule : ddr_tx_model

// >>> verification/ddr_input_deserializer_path_tb_top.sv
// Self-checking bench: word stream per ratio, stall, slip, tap control.
// Assumes the transmitter model file; expected words from a bit history.
`timescale 1ns/10ps
module ddr_input_deserializer_path_tb_top import ddr_rx_pkg::*;;
	localparam logic [TAP_W-1:0] STATIC_T = 8'h00; // Zero so data is undelayed
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic bankFastIoClk, padData;
	logic [1:0] delayMode = 2'h0, ratioSel = 2'h0;
	logic [TAP_W-1:0] dllCode = 8'h00, trainValue = 8'h00;
	logic trainLoad = 1'b0, trainInc = 1'b0, trainDec = 1'b0;
	logic slipEnable = 1'b0, wordAlignSlip = 1'b0, wordReady = 1'b0, stallOn = 1'b0;
	logic [WORD_W-1:0] wordData, heldWord;
	logic wordValid, tapBusy, held = 1'b0;
	bit tapDone = 1'b0; // Ends the zero stream once the tap tests finish
	logic [TAP_W-1:0] tapNow;
	int fail_count = 0, cmp_count = 0, cycles = 0, pos = 0;
	int bitsOf[4] = '{int'(BITS_X2), int'(BITS_X3P5), int'(BITS_X4), int'(BITS_X5)};
	bit hist[$]; // Every counted bit sent, oldest first
	logic [WORD_W-1:0] expQ[$]; // Expected words, oldest first

	ddr_tx_model ddr_tx_model_inst (.linkClk(bankFastIoClk), .padData(padData));
	ddr_input_deserializer_path #(.STATIC_TAP(STATIC_T)) ddr_input_deserializer_path_inst (
		.core_clk(core_clk), .resetn(resetn), .bankFastIoClk(bankFastIoClk),
		.padData(padData), .delayMode(delayMode), .dllCode(dllCode),
		.trainLoad(trainLoad), .trainValue(trainValue), .trainInc(trainInc),
		.trainDec(trainDec), .ratioSel(ratioSel), .slipEnable(slipEnable),
		.wordAlignSlip(wordAlignSlip), .wordReady(wordReady), .wordData(wordData),
		.wordValid(wordValid), .tapNow(tapNow), .tapBusy(tapBusy));

	// 250 MHz core clock
	always #2 core_clk = ~core_clk;

	// Fabric back-pressure, random unless a stall is wanted
	always @(negedge core_clk) wordReady <= !stallOn && ($urandom % 4 != 0);

	task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// Hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			$display("mismatch timeout expected finish seen hang");
			report_and_stop();
		end
	end

	// Monitor: take the oldest note on each accepted word
	always @(posedge core_clk) begin
		if (held)
			check("held word", wordData, heldWord);
		if (wordValid === 1'b1 && wordReady === 1'b1) begin
			if (expQ.size() == 0)
				check("extra word", wordData, 'x);
			else
				check("word", wordData, expQ.pop_front());
		end
		held <= wordValid === 1'b1 && wordReady !== 1'b1;
		heldWord <= wordData;
	end

	// Random pairs; whole words noted, oldest bit at the top
	task automatic sendFrame(input int pairs, input bit zeros = 1'b0);
		int n;
		bit b;
		logic [WORD_W-1:0] w;
		n = bitsOf[ratioSel];
		for (int i = 0; i < 2 * pairs; i++) begin
			b = zeros ? 1'b0 : 1'($urandom);
			hist.push_back(b);
			ddr_tx_model_inst.txBits.push_back(b);
		end
		while (pos + n <= hist.size()) begin
			w = '0;
			for (int k = 0; k < n; k++)
				w[n - 1 - k] = hist[pos + k];
			expQ.push_back(w);
			pos += n;
		end
		ddr_tx_model_inst.sendPairs(pairs);
	endtask : sendFrame

	// Wait until every noted word has come out, then expect idle
	task automatic drain(input string name);
		for (int i = 0; i < 3000 && expQ.size() > 0; i++)
			@(negedge core_clk);
		repeat (10) @(negedge core_clk);
		check("words left", WORD_W'(expQ.size()), '0);
		check("valid idle", WORD_W'(wordValid), '0);
		$display("test %s done", name);
	endtask : drain

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
		@(negedge core_clk);
	endtask : pulse

	// Tap change crosses to the link side; wait for it to land
	task automatic settleTap(input logic [TAP_W-1:0] exp);
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 50 && tapBusy !== 1'b0; i++)
			@(negedge core_clk);
		check("tap busy", WORD_W'(tapBusy), '0);
		check("tap", WORD_W'(tapNow), WORD_W'(exp));
	endtask : settleTap

	initial begin
		void'($urandom(32'h727fbf16));
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		// Two rising edges release the link reset copy; the second falling edge
		// already writes a pair with a zero rise bit, so both priming pairs are
		// zero and that last pair leads the expected stream
		ddr_tx_model_inst.txBits = '{1'b0, 1'b0, 1'b0, 1'b0};
		ddr_tx_model_inst.sendPairs(2);
		hist = '{1'b0, 1'b0};
		repeat (4) @(negedge core_clk);
		// 280 bits per frame; the two priming bits ride along as leftover
		for (int r = 0; r < 4; r++) begin
			ratioSel = 2'(r);
			@(negedge core_clk);
			sendFrame(140);
			drain("ratio");
		end
		// Stall: nine words just fill the buffer; only two leftover bits stay in the gearbox
		stallOn = 1'b1;
		ratioSel = RATIO_X5;
		sendFrame(45);
		repeat (80) @(negedge core_clk);
		check("valid stalled", WORD_W'(wordValid), 10'h001);
		stallOn = 1'b0;
		drain("stall");
		// slip ignored when disabled and at ratio 3.5
		for (int i = 0; i < 2; i++) begin
			ratioSel = i ? RATIO_X3P5 : RATIO_X2;
			slipEnable = 1'(i);
			pulse(wordAlignSlip);
			sendFrame(140);
			drain("slip ignored");
		end
		// slip moves the boundary one bit earlier
		for (int r = 0; r < 3; r++) begin
			ratioSel = r ? 2'(r + 1) : RATIO_X2;
			pulse(wordAlignSlip);
			pos -= 1;
			sendFrame(140);
			drain("slip");
		end
		// Tap moves cross on link edges, so the link clock must run; 260 zero
		// pairs flush both delay histories, so every tap then reads zeros
		sendFrame(260, 1'b1);
		fork
			begin
				// Zero stream keeps link edges coming while taps move
				while (!tapDone)
					sendFrame(20, 1'b1);
			end
			begin
				// training loads, steps, saturates; inc beats dec
				delayMode = 2'h2;
				trainValue = 8'hFE;
				pulse(trainLoad);
				settleTap(8'hFE);
				pulse(trainInc);
				pulse(trainInc);
				settleTap(TAP_MAX);
				pulse(trainDec);
				settleTap(8'hFE);
				trainInc = 1'b1;
				pulse(trainDec);
				trainInc = 1'b0;
				settleTap(TAP_MAX);
				trainValue = TAP_RST;
				pulse(trainLoad);
				pulse(trainDec);
				settleTap(TAP_RST);
				$display("test training done");
				// dynamic tap follows the loop code
				delayMode = 2'h1;
				for (int i = 0; i < 2; i++) begin
					dllCode = 8'($urandom);
					settleTap(dllCode);
				end
				// static mode returns to the fixed tap
				delayMode = 2'h0;
				settleTap(STATIC_T);
				tapDone = 1'b1;
			end
		join
		drain("delay modes");
		report_and_stop();
	end
endmodule : ddr_input_deserializer_path_tb_top
